// File: rtl/mchp_host_port.sv
// Purpose: Multiplexed 8-bit host port, emergency flags, sync and index handling
// Assumes: Strobes active low, sampled on sys_clk; outputs registered except bus_oe
// Notes: Control filters, commutator and PWM live elsewhere; hooks only here
// How it works
// - Low six bus lines carry address then data in each access.
// - Top two bus lines carry data only, never address.
// - Read/write level chooses direction of a chip-select access.
// - Address strobe low latches low six lines as the address.
// - Write access stores bus byte at the latched address.
// - Read access copies addressed location into output latch, no drive.
// - Output latch drives bus only while output enable is low.
// - Status and command outputs hold each value at least one clock.
// - Motor command write appears on outputs within 3.2 clocks.
// - Limit flag forces idle mode and zero motor command.
// - Limit flag state is readable in the status register.
// - Stop flag in velocity mode decelerates command to standstill.
// - Reset input loads reset values into all registers but the location array and enters reset mode.
// - Index of either polarity is used only for the commutator.
// - Sync input aligns sample timers of several devices.
// - In idle, sync low clears and holds timer; release reloads it.
// - Limit or stop clears after input high and a status write.
`timescale 1ns/1ps
module mchp_host_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host bus
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic [7:0] bus_oe,
  input wire mchp_pkg::mchp_strobe_s strobe,
  // Emergency, sync and index
  input wire logic limit_n,
  input wire logic stop_n,
  input wire logic sync_n,
  input wire logic index_in,
  // Control core hooks
  input wire logic [7:0] core_motor_cmd,
  input wire logic core_cmd_valid,
  input wire logic prof_in,
  output logic index_event,
  output logic sample_tick,
  // Device outputs
  output logic [7:0] motor_command_port,
  output logic init_flag,
  output logic prof_flag,
  output logic [1:0] mode_state
);

  ////////////////////////////////////////////////////////////////////
  // Host port
  logic [7:0] mem_reg [mchp_pkg::NUM_LOC];
  logic [5:0] addr_reg, addr_next;
  logic [7:0] olatch_reg, olatch_next;
  logic cs_d_reg;
  logic cs_fall;
  logic wr_now;
  logic [7:0] rd_val;

  assign cs_fall = cs_d_reg && !strobe.cs_n;
  assign wr_now = cs_fall && !strobe.rd_wr_n;

  always_comb begin
    addr_next = addr_reg;
    if (!strobe.ale_n) begin
      addr_next = bus_in[5:0];
    end
  end

  logic limit_flag_reg, limit_flag_next;
  logic stop_flag_reg, stop_flag_next;
  logic [3:0] status_cfg_reg, status_cfg_next;

  always_comb begin
    rd_val = mem_reg[addr_reg];
    if (addr_reg == mchp_pkg::STATUS_LOC) begin
      rd_val = 8'h00;
      rd_val[3:0] = status_cfg_reg;
      rd_val[mchp_pkg::STATUS_LIMIT_BIT] = limit_flag_reg;
      rd_val[mchp_pkg::STATUS_STOP_BIT] = stop_flag_reg;
    end else if (addr_reg == mchp_pkg::MOTOR_CMD_LOC) begin
      rd_val = motor_command_port;
    end
    olatch_next = olatch_reg;
    if (cs_fall && strobe.rd_wr_n) begin
      olatch_next = rd_val;
    end
  end

  // Latch only feeds the pins under output enable; host owns the timing after CS
  assign bus_out = olatch_reg;
  assign bus_oe = (!strobe.oe_n && strobe.rd_wr_n) ? 8'hFF : 8'h00;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= '0;
      olatch_reg <= mchp_pkg::LOC_RESET_VAL;
      cs_d_reg <= 1'b1;
    end else begin
      addr_reg <= addr_next;
      olatch_reg <= olatch_next;
      cs_d_reg <= strobe.cs_n;
    end
  end

  // Array has no reset; software must program it after reset
  always_ff @(posedge sys_clk) begin
    if (wr_now) begin
      mem_reg[addr_reg] <= bus_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Emergency flags and mode
  logic status_wr;
  mchp_pkg::mchp_mode_e mode_reg, mode_next;
  logic [7:0] mc_reg, mc_next;
  logic [7:0] period_reg, period_next;

  assign status_wr = wr_now && (addr_reg == mchp_pkg::STATUS_LOC);

  always_comb begin
    limit_flag_next = limit_flag_reg;
    stop_flag_next = stop_flag_reg;
    status_cfg_next = status_cfg_reg;
    if (status_wr) begin
      status_cfg_next = bus_in[3:0];
      if (limit_n) begin
        limit_flag_next = 1'b0;
      end
      if (stop_n) begin
        stop_flag_next = 1'b0;
      end
    end
    // Set wins over the clear
    if (!limit_n) begin
      limit_flag_next = 1'b1;
    end
    if (!stop_n) begin
      stop_flag_next = 1'b1;
    end
  end

  always_comb begin
    mode_next = mode_reg;
    mc_next = mc_reg;
    period_next = period_reg;
    if (wr_now && addr_reg == mchp_pkg::SAMPLE_PERIOD_LOC) begin
      period_next = bus_in;
    end
    unique case (mode_reg)
      mchp_pkg::MODE_RESET: begin
        mode_next = mchp_pkg::MODE_IDLE;
      end
      mchp_pkg::MODE_IDLE: begin
        if (wr_now && addr_reg == mchp_pkg::MODE_LOC && !limit_flag_reg) begin
          mode_next = bus_in[0] ? mchp_pkg::MODE_VELOCITY : mchp_pkg::MODE_CONTROL;
        end
      end
      mchp_pkg::MODE_CONTROL: begin
        if (core_cmd_valid) begin
          mc_next = core_motor_cmd;
        end
      end
      mchp_pkg::MODE_VELOCITY: begin
        if (stop_flag_reg) begin
          // Offset-binary: 8'h80 is standstill
          if (mc_reg > 8'h80) begin
            mc_next = mc_reg - mchp_pkg::DECEL_STEP;
          end else if (mc_reg < 8'h80) begin
            mc_next = mc_reg + mchp_pkg::DECEL_STEP;
          end
        end else if (core_cmd_valid) begin
          mc_next = core_motor_cmd;
        end
      end
    endcase
    if (wr_now && addr_reg == mchp_pkg::MOTOR_CMD_LOC) begin
      mc_next = bus_in;
    end
    if (wr_now && addr_reg == mchp_pkg::MODE_LOC && mode_reg != mchp_pkg::MODE_IDLE) begin
      mode_next = mchp_pkg::MODE_IDLE;
    end
    if (limit_flag_reg && mode_reg != mchp_pkg::MODE_RESET) begin
      mode_next = mchp_pkg::MODE_IDLE;
      mc_next = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_flag_reg <= 1'b0;
      stop_flag_reg <= 1'b0;
      status_cfg_reg <= 4'h0;
      mode_reg <= mchp_pkg::MODE_RESET;
      mc_reg <= mchp_pkg::LOC_RESET_VAL;
      period_reg <= mchp_pkg::SAMPLE_PERIOD_RESET;
    end else begin
      limit_flag_reg <= limit_flag_next;
      stop_flag_reg <= stop_flag_next;
      status_cfg_reg <= status_cfg_next;
      mode_reg <= mode_next;
      mc_reg <= mc_next;
      period_reg <= period_next;
    end
  end

  // Registered outputs hold a full clock at least
  assign motor_command_port = mc_reg;
  assign mode_state = mode_reg;

  ////////////////////////////////////////////////////////////////////
  // Sample timer, sync and index
  logic [4:0] pre_reg, pre_next;
  logic [7:0] timer_reg, timer_next;
  logic sync_hold;
  logic idx_d_reg, idx_ev_next, idx_ev_reg;
  logic tick_next, tick_reg;
  logic init_reg, prof_reg;

  assign sync_hold = !sync_n && mode_reg == mchp_pkg::MODE_IDLE;

  always_comb begin
    pre_next = pre_reg;
    timer_next = timer_reg;
    tick_next = 1'b0;
    if (sync_hold) begin
      pre_next = '0;
      timer_next = 8'h00;
    end else if (timer_reg == 8'h00 && pre_reg == 5'd0) begin
      timer_next = period_reg;
      pre_next = 5'(mchp_pkg::SAMPLE_TICK_CYC - 1);
      tick_next = 1'b1;
    end else if (pre_reg == 5'd0) begin
      timer_next = timer_reg - 8'h01;
      pre_next = 5'(mchp_pkg::SAMPLE_TICK_CYC - 1);
    end else begin
      pre_next = pre_reg - 5'd1;
    end
    // Any edge counts so either index polarity works
    idx_ev_next = index_in != idx_d_reg;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= '0;
      timer_reg <= 8'h00;
      tick_reg <= 1'b0;
      idx_d_reg <= 1'b0;
      idx_ev_reg <= 1'b0;
      init_reg <= 1'b0;
      prof_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      timer_reg <= timer_next;
      tick_reg <= tick_next;
      idx_d_reg <= index_in;
      idx_ev_reg <= idx_ev_next;
      init_reg <= mode_next == mchp_pkg::MODE_IDLE;
      prof_reg <= prof_in && mode_next == mchp_pkg::MODE_CONTROL;
    end
  end

  assign index_event = idx_ev_reg;
  assign sample_tick = tick_reg;
  assign init_flag = init_reg;
  assign prof_flag = prof_reg;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  a_limit_forces_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    limit_flag_reg && mode_reg != mchp_pkg::MODE_RESET |=> mode_reg == mchp_pkg::MODE_IDLE
      && mc_reg == 8'h00) else $error("limit did not force idle");
  a_mc_write_fast: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_now && addr_reg == mchp_pkg::MOTOR_CMD_LOC && !limit_flag_reg
      |=> motor_command_port == $past(bus_in)) else $error("motor command late");
  a_bus_quiet_no_oe: assert property (@(posedge sys_clk) disable iff (!reset_n)
    strobe.oe_n |-> bus_oe == 8'h00) else $error("bus driven without oe");
  a_read_latches_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cs_fall && strobe.rd_wr_n |=> olatch_reg == $past(rd_val)) else $error("read latch bad");
  a_addr_capture: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !strobe.ale_n |=> addr_reg == $past(bus_in[5:0])) else $error("address not latched");
  a_limit_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    limit_flag_reg && !status_wr |=> limit_flag_reg) else $error("limit cleared early");
  a_limit_status_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !limit_n |=> limit_flag_reg ##1 limit_flag_reg) else $error("limit not set");
  a_sync_holds_timer: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sync_hold |=> timer_reg == 8'h00) else $error("sync did not clear timer");
  a_reset_then_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_reg == mchp_pkg::MODE_RESET |=> mode_reg == mchp_pkg::MODE_IDLE)
    else $error("reset mode stuck");
  a_stop_decel: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_reg == mchp_pkg::MODE_VELOCITY && stop_flag_reg && !limit_flag_reg && !wr_now
      && mc_reg > 8'h80 |=> mc_reg == $past(mc_reg) - 8'h01) else $error("no decel");
  c_write: cover property (@(posedge sys_clk) disable iff (!reset_n) wr_now);
  c_read_oe: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cs_fall && strobe.rd_wr_n ##[1:20] !strobe.oe_n);
  c_limit_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    limit_flag_reg ##1 !limit_flag_reg);
  c_sync: cover property (@(posedge sys_clk) disable iff (!reset_n) sync_hold ##1 !sync_hold);
endmodule

// File: rtl/mchp_pkg.sv
// Purpose: Shared constants and types for the motion controller host port
// Assumes: 100 MHz sys_clk, all inputs synchronous to it
// Notes: Register locations are internal indices on the 6-bit address
package mchp_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NUM_LOC = 64;
  localparam logic [5:0] STATUS_LOC = 6'h07;
  localparam logic [5:0] MOTOR_CMD_LOC = 6'h08;
  localparam logic [5:0] SAMPLE_PERIOD_LOC = 6'h0F;
  localparam logic [5:0] MODE_LOC = 6'h05;
  localparam int STATUS_LIMIT_BIT = 4;
  localparam int STATUS_STOP_BIT = 5;
  localparam int STATUS_CFG_W = 4;
  localparam logic [7:0] LOC_RESET_VAL = 8'h00;
  localparam logic [7:0] SAMPLE_PERIOD_RESET = 8'h40;
  // Sample timer prescale in sys_clk cycles per timer tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_TICK_NS = 160;
  localparam int SAMPLE_TICK_CYC = (SAMPLE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 5;
  // Motor command update bound after chip select rise: 3.2 device clocks
  localparam int MC_UPDATE_MAX_CYC = 3;
  localparam int SYNC_LOW_MIN_CYC = 18;
  localparam logic [7:0] DECEL_STEP = 8'h01;

  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_IDLE,
    MODE_CONTROL,
    MODE_VELOCITY
  } mchp_mode_e;

  typedef struct packed {
    logic ale_n;
    logic cs_n;
    logic oe_n;
    logic rd_wr_n;
  } mchp_strobe_s;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] doe;
  } mchp_bus_out_s;
endpackage

// File: bench/mchp_host_model.sv
// Purpose: Host processor model for the multiplexed host port
// Assumes: All strobes change on the falling edge of sys_clk
// Notes: Released bus lines show the inverse of the last byte
`timescale 1ns/1ps
module mchp_host_model (
  // Clock
  input wire logic sys_clk,
  // Host bus
  output logic [7:0] host_d,
  output mchp_pkg::mchp_strobe_s strobe,
  // Sync
  output logic sync_n
);
  // Waits in sys_clk cycles, rounded up from three clocks plus the ns term
  localparam int DATA_WAIT = 6;
  localparam int ALE_WAIT = 7;

  initial begin
    strobe = '1;
    host_d = 8'h00;
    sync_n = 1'b1;
  end

  ////////////////////////////////////////
  task automatic cyc(input logic [5:0] a, input logic [7:0] d, input logic rd);
    @(negedge sys_clk);
    strobe.ale_n = 1'b0;
    // Top lines carry junk during the address phase
    host_d = {~d[7:6], a};
    @(negedge sys_clk);
    strobe.ale_n = 1'b1;
    strobe.cs_n = 1'b0;
    strobe.rd_wr_n = rd;
    host_d = rd ? ~host_d : d;
    repeat (2) @(negedge sys_clk);
    strobe.cs_n = 1'b1;
    host_d = ~host_d;
    if (rd) begin
      repeat (DATA_WAIT) @(negedge sys_clk);
      strobe.oe_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      strobe.oe_n = 1'b1;
    end
    repeat (ALE_WAIT) @(negedge sys_clk);
  endtask

  task automatic sync_pulse(input int n);
    @(negedge sys_clk);
    sync_n = 1'b0;
    repeat (n) @(negedge sys_clk);
    sync_n = 1'b1;
  endtask
endmodule

// File: bench/mchp_host_port_tb.sv
// Purpose: Self-checking bench for the host port
// Assumes: Host model paces the bus, bench drives the rest
// Notes: Read data is queued by the driver and checked by the monitor
`timescale 1ns/1ps
module mchp_host_port_tb;
  logic sys_clk, reset_n, limit_n, stop_n, index_in, core_cmd_valid, prof_in;
  logic [7:0] core_motor_cmd, host_d, bus_out, bus_oe, motor_command_port;
  logic index_event, sample_tick, init_flag, prof_flag, sync_n;
  logic [1:0] mode_state;
  mchp_pkg::mchp_strobe_s strobe;
  wire logic [7:0] bus_wire = (bus_oe & bus_out) | (~bus_oe & host_d);
  logic [7:0] rd_q[$];
  logic [7:0] mc_q[$];
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'h9ad5_2995;
  int ticks = 0;
  int idx = 0;
  int cs_cnt = 0;
  logic oe_d = 1'b1;

  mchp_host_port mchp_host_port_i (.sys_clk, .reset_n, .bus_in(bus_wire), .bus_out,
    .bus_oe, .strobe, .limit_n, .stop_n, .sync_n, .index_in, .core_motor_cmd,
    .core_cmd_valid, .prof_in, .index_event, .sample_tick, .motor_command_port,
    .init_flag, .prof_flag, .mode_state);
  mchp_host_model mchp_host_model_i (.sys_clk, .host_d, .strobe, .sync_n);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic w(input logic [5:0] a, input logic [7:0] d);
    mchp_host_model_i.cyc(a, d, 1'b0);
  endtask

  task automatic r(input logic [5:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    mchp_host_model_i.cyc(a, 8'h00, 1'b1);
  endtask

  ////////////////////////////////////////
  // Monitor: takes the oldest note whenever a result shows
  always @(posedge sys_clk) begin
    oe_d <= bus_oe[0];
    cs_cnt <= strobe.cs_n ? cs_cnt + 1 : 0;
    if (bus_oe === 8'hff && oe_d === 1'b0) begin
      chk("read data", rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, bus_wire);
    end
    if (!strobe.cs_n) begin
      chk("oe in access", 8'h00, bus_oe);
    end
    if (mc_q.size() > 0 && strobe.cs_n && cs_cnt == 2) begin
      chk("mc update", mc_q.pop_front(), motor_command_port);
    end
    ticks += sample_tick;
    idx += index_event;
  end

  initial begin
    #100us;
    n_fail++;
    conclude();
  end

  initial begin
    logic [5:0] a;
    logic [7:0] d;
    reset_n = 1'b0;
    limit_n = 1'b1;
    stop_n = 1'b1;
    index_in = 1'b0;
    core_cmd_valid = 1'b0;
    core_motor_cmd = 8'h00;
    prof_in = 1'b0;
    tick(10);
    chk("mode", 8'h00, {6'h00, mode_state});
    chk("mc", 8'h00, motor_command_port);
    reset_n = 1'b1;
    tick(3);
    chk("init", 8'h01, {7'h00, init_flag});
    $display("reset test done");
    // Plain locations only, away from the live ones below 10h
    for (int i = 0; i < 8; i++) begin
      a = 6'h10 + 6'(($random(seed) & 32'h7fff_ffff) % 48);
      d = 8'($random(seed));
      w(a, d);
      r(a, d);
    end
    mc_q.push_back(8'hc3);
    w(mchp_pkg::MOTOR_CMD_LOC, 8'hc3);
    r(mchp_pkg::MOTOR_CMD_LOC, 8'hc3);
    $display("bus test done");
    w(mchp_pkg::MODE_LOC, 8'h00);
    core_cmd_valid = 1'b1;
    core_motor_cmd = 8'h33;
    prof_in = 1'b1;
    tick(3);
    chk("mode", 8'h02, {6'h00, mode_state});
    chk("mc", 8'h33, motor_command_port);
    chk("prof", 8'h01, {7'h00, prof_flag});
    limit_n = 1'b0;
    tick(2);
    chk("mode", 8'h01, {6'h00, mode_state});
    chk("mc", 8'h00, motor_command_port);
    core_cmd_valid = 1'b0;
    w(mchp_pkg::STATUS_LOC, 8'h03);
    r(mchp_pkg::STATUS_LOC, 8'h13);
    limit_n = 1'b1;
    r(mchp_pkg::STATUS_LOC, 8'h13);
    w(mchp_pkg::STATUS_LOC, 8'h00);
    r(mchp_pkg::STATUS_LOC, 8'h00);
    $display("limit test done");
    w(mchp_pkg::MODE_LOC, 8'h01);
    core_cmd_valid = 1'b1;
    core_motor_cmd = 8'h90;
    tick(2);
    core_cmd_valid = 1'b0;
    stop_n = 1'b0;
    tick(20);
    chk("mc", 8'h80, motor_command_port);
    chk("mode", 8'h03, {6'h00, mode_state});
    r(mchp_pkg::STATUS_LOC, 8'h20);
    stop_n = 1'b1;
    w(mchp_pkg::STATUS_LOC, 8'h00);
    w(mchp_pkg::MODE_LOC, 8'h00);
    chk("init", 8'h01, {7'h00, init_flag});
    $display("stop test done");
    w(mchp_pkg::SAMPLE_PERIOD_LOC, 8'h02);
    fork
      mchp_host_model_i.sync_pulse(mchp_pkg::SYNC_LOW_MIN_CYC);
      begin
        tick(3);
        ticks = 0;
      end
    join
    chk("ticks low", 8'h00, 8'(ticks));
    tick(60);
    chk("ticks run", 8'h01, {7'h00, ticks > 0});
    $display("sync test done");
    for (int i = 0; i < 4; i++) begin
      index_in = ~index_in;
      tick(5);
    end
    chk("index", 8'h04, 8'(idx));
    chk("reads left", 8'h00, 8'(rd_q.size()));
    $display("index test done");
    conclude();
  end
endmodule
